// ==== hdl/gpdi_port.sv ====
// Overview of operation
// - Three-bit drive code held per pin
// - Output from data bit or bypass logic
// - Code 0: no driver, no input, reset
// - Code 1: high impedance, input enabled
// - Codes 2,3: resistive one side, strong other
// - Codes 4,5: open drain low or high
// - Code 6: strong high and low
// - Code 7: resistive both levels
// - Regulated special pins refuse resistive codes
// - Port-form registers, one bit per pin
// - Pin-form register groups eight pin bits
// - Both forms share the same state
// - Aux enable switches output versus input
// - Sixteen aux enables routable to pins
// - Slew bit only in strong, open-drain modes
// - Eight pins feed one port interrupt
// - Per-pin none, rise, fall or both
// - Edge sets status bit, raises request
// - Edge detection runs in all sleep modes
// - No level-sensitive detection
// - Port threshold select, per-pin input disable
// - Pins hold state through low power
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module gpdi_port
	import gpdi_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [gpdi_pkg::PINS-1:0] pinIn,
	output logic [gpdi_pkg::PINS-1:0] pinOut,
	output logic [gpdi_pkg::PINS-1:0] pinStrongEn,
	output logic [gpdi_pkg::PINS-1:0] pinResEn,
	output logic [gpdi_pkg::PINS-1:0] pinSlowSlew,
	output logic [gpdi_pkg::PINS-1:0] pinInBufEn,
	output logic lvttlSelect,
	input wire logic [gpdi_pkg::PINS-1:0] logicOut,
	input wire logic [gpdi_pkg::AUX_LINES-1:0] auxOutEn,
	output logic [gpdi_pkg::PINS-1:0] pinInValue,
	output logic portIrq
);
	import gpdi_pkg::*;

	// ==========================================
	// Configuration state (outValue to inDisable shared by both forms)
	logic [PINS-1:0] outValue;
	logic [2:0] driveCode [PINS];
	logic [PINS-1:0] bypass;
	logic [PINS-1:0] slew;
	logic [PINS-1:0] inDisable;
	logic [1:0] portCtl;
	logic [1:0] irqType [PINS];
	logic [PINS-1:0] irqStatus;
	logic [PINS-1:0] auxEn;
	logic [AUX_SEL_W-1:0] auxSel [PINS];
	logic [PINS-1:0] specialPin;
	logic [PINS-1:0] syncA, syncB, syncPrev;
	logic [PINS-1:0] edgeHit;

	// ==========================================
	// AXI4-Lite handshake
	logic awHeld, wHeld;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite, doRead;
	logic [7:0] rAddr;
	logic [31:0] next_rdata;
	logic rdHit;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr[7:0];
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wHeld <= 1'b0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	function automatic logic wrHit(input logic [7:0] a);
		wrHit = (a[1:0] == 2'h0) && ((a <= OFS_SPECIAL && a != OFS_PIN_STATE)
			|| (a >= OFS_PIN_BASE && a < OFS_PIN_BASE + 8'(4 * PINS)));
	endfunction

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrHit(awAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign doRead = s_axi_arvalid && s_axi_arready;
	assign rAddr = s_axi_araddr[7:0];

	// Ready flags registered from the next handshake state
	logic next_awHeld, next_wHeld, next_bvalid, next_rvalid;
	always_comb begin
		next_awHeld = (s_axi_awvalid && s_axi_awready) || (awHeld && !doWrite);
		next_wHeld = (s_axi_wvalid && s_axi_wready) || (wHeld && !doWrite);
		next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
		next_rvalid = doRead || (s_axi_rvalid && !s_axi_rready);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= !next_awHeld && !next_bvalid;
			s_axi_wready <= !next_wHeld && !next_bvalid;
			s_axi_arready <= !next_rvalid;
		end
	end

	// ==========================================
	// Per-pin register writes, either form
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : gPin
			localparam logic [7:0] PIN_OFS = OFS_PIN_BASE + 8'(4 * g);
			logic portWr, pinWr;
			logic [2:0] wantCode;
			assign portWr = doWrite && wStrb[0];
			assign pinWr = doWrite && wStrb[0] && awAddr == PIN_OFS;
			assign wantCode = pinWr ? wData[PF_DRIVE_HI:PF_DRIVE_LO]
				: {awAddr == OFS_DRIVE2 ? wData[g] : driveCode[g][2],
				awAddr == OFS_DRIVE1 ? wData[g] : driveCode[g][1],
				awAddr == OFS_DRIVE0 ? wData[g] : driveCode[g][0]};

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					driveCode[g] <= DRV_HIZ_ANALOG;
				end else if (pinWr || (portWr && (awAddr == OFS_DRIVE0
					|| awAddr == OFS_DRIVE1 || awAddr == OFS_DRIVE2))) begin
					// Resistive codes refused on regulated special pins
					if (!(specialPin[g] && portCtl[PC_REGULATED]
						&& (wantCode == DRV_RES_UP || wantCode == DRV_RES_DOWN
						|| wantCode == DRV_RES_BOTH))) begin
						driveCode[g] <= wantCode;
					end
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					outValue[g] <= 1'b0;
					bypass[g] <= 1'b0;
					slew[g] <= 1'b0;
					inDisable[g] <= 1'b0;
				end else if (pinWr) begin
					outValue[g] <= wData[PF_OUT];
					bypass[g] <= wData[PF_BYPASS];
					slew[g] <= wData[PF_SLEW];
					inDisable[g] <= wData[PF_IN_DIS];
				end else if (portWr) begin
					if (awAddr == OFS_OUT_VALUE)
						outValue[g] <= wData[g];
					if (awAddr == OFS_BYPASS)
						bypass[g] <= wData[g];
					if (awAddr == OFS_SLEW)
						slew[g] <= wData[g];
					if (awAddr == OFS_IN_DISABLE)
						inDisable[g] <= wData[g];
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					irqType[g] <= IT_NONE;
					auxEn[g] <= 1'b0;
					auxSel[g] <= '0;
					specialPin[g] <= 1'b0;
				end else if (doWrite) begin
					if (awAddr == OFS_IRQ_TYPE && wStrb[g/4])
						irqType[g] <= wData[2*g+:2];
					if (awAddr == OFS_AUX_EN && wStrb[0])
						auxEn[g] <= wData[g];
					if (awAddr == OFS_AUX_SEL && wStrb[g/2])
						auxSel[g] <= wData[AUX_SEL_W*g+:AUX_SEL_W];
					if (awAddr == OFS_SPECIAL && wStrb[0])
						specialPin[g] <= wData[g];
				end
			end

			// Edge qualifier per type; no level mode exists
			assign edgeHit[g] = (syncB[g] && !syncPrev[g] && irqType[g][0])
				|| (!syncB[g] && syncPrev[g] && irqType[g][1]);

			// Pin drive decode
			logic data, oeOk, hi, strongOn, resOn;
			always_comb begin
				data = bypass[g] ? logicOut[g] : outValue[g];
				oeOk = !auxEn[g] || auxOutEn[auxSel[g]];
				hi = data;
				strongOn = 1'b0;
				resOn = 1'b0;
				case (driveCode[g])
					DRV_HIZ_ANALOG, DRV_HIZ_DIGITAL: begin
					end
					DRV_RES_UP: begin
						strongOn = !data;
						resOn = data;
					end
					DRV_RES_DOWN: begin
						strongOn = data;
						resOn = !data;
					end
					DRV_OD_LOW: strongOn = !data;
					DRV_OD_HIGH: strongOn = data;
					DRV_STRONG: strongOn = 1'b1;
					DRV_RES_BOTH: resOn = 1'b1;
					default: begin
					end
				endcase
				if (!oeOk) begin
					strongOn = 1'b0;
					resOn = 1'b0;
				end
			end

			// Outputs registered; state held until changed
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					pinOut[g] <= 1'b0;
					pinStrongEn[g] <= 1'b0;
					pinResEn[g] <= 1'b0;
					pinSlowSlew[g] <= 1'b0;
					pinInBufEn[g] <= 1'b0;
					pinInValue[g] <= 1'b0;
				end else begin
					pinOut[g] <= hi;
					pinStrongEn[g] <= strongOn;
					pinResEn[g] <= resOn;
					// Codes 2 and 3 are resistive modes: no slow edge
					pinSlowSlew[g] <= slew[g] && strongOn
						&& driveCode[g][2];
					pinInBufEn[g] <= driveCode[g] != DRV_HIZ_ANALOG
						&& !inDisable[g];
					pinInValue[g] <= syncB[g] && driveCode[g] != DRV_HIZ_ANALOG
						&& !inDisable[g];
				end
			end
		end
	endgenerate

	// ==========================================
	// Port control and input synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			portCtl <= 2'h0;
		else if (doWrite && wStrb[0] && awAddr == OFS_PORT_CTL)
			portCtl <= wData[1:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lvttlSelect <= 1'b0;
		else
			lvttlSelect <= portCtl[PC_LVTTL];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncA <= RST_BYTE;
			syncB <= RST_BYTE;
			syncPrev <= RST_BYTE;
		end else begin
			syncA <= pinIn;
			syncB <= syncA;
			syncPrev <= syncB;
		end
	end

	// ==========================================
	// Edge interrupt unit; runs on the always-on clock
	logic statusRead;
	assign statusRead = doRead && rAddr == OFS_IRQ_STATUS;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			irqStatus <= RST_BYTE;
		else
			irqStatus <= (irqStatus & ~(statusRead ? 8'hFF : 8'h00))
				| edgeHit;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			portIrq <= 1'b0;
		else
			portIrq <= |((irqStatus & ~(statusRead ? 8'hFF : 8'h00))
				| edgeHit);
	end

	// ==========================================
	// Read mux
	logic [PINS-1:0] d0, d1, d2;
	logic [2*PINS-1:0] typeWord;
	logic [AUX_SEL_W*PINS-1:0] selWord;
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			d0[i] = driveCode[i][0];
			d1[i] = driveCode[i][1];
			d2[i] = driveCode[i][2];
			typeWord[2*i+:2] = irqType[i];
			selWord[AUX_SEL_W*i+:AUX_SEL_W] = auxSel[i];
		end
		rdHit = 1'b1;
		next_rdata = 32'h00000000;
		case (rAddr)
			OFS_OUT_VALUE: next_rdata[7:0] = outValue;
			OFS_DRIVE0: next_rdata[7:0] = d0;
			OFS_DRIVE1: next_rdata[7:0] = d1;
			OFS_DRIVE2: next_rdata[7:0] = d2;
			OFS_BYPASS: next_rdata[7:0] = bypass;
			OFS_SLEW: next_rdata[7:0] = slew;
			OFS_IN_DISABLE: next_rdata[7:0] = inDisable;
			OFS_PORT_CTL: next_rdata[1:0] = portCtl;
			OFS_PIN_STATE: next_rdata[7:0] = syncB;
			OFS_IRQ_TYPE: next_rdata[15:0] = typeWord;
			OFS_IRQ_STATUS: next_rdata[7:0] = irqStatus;
			OFS_AUX_EN: next_rdata[7:0] = auxEn;
			OFS_AUX_SEL: next_rdata = selWord;
			OFS_SPECIAL: next_rdata[7:0] = specialPin;
			default: begin
				rdHit = 1'b0;
				for (int i = 0; i < PINS; i++) begin
					if (rAddr == OFS_PIN_BASE + 8'(4 * i)) begin
						rdHit = 1'b1;
						next_rdata[7:0] = {syncB[i], inDisable[i], slew[i],
							bypass[i], driveCode[i], outValue[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (doRead) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ==== pkg/gpdi_pkg.sv ====
package gpdi_pkg;
	// ==========================================
	// Port geometry
	localparam int PINS = 8;
	localparam int AUX_LINES = 16;
	localparam int AUX_SEL_W = 4;

	// ==========================================
	// Drive mode codes
	typedef enum logic [2:0] {
		DRV_HIZ_ANALOG = 3'h0,
		DRV_HIZ_DIGITAL = 3'h1,
		DRV_RES_UP = 3'h2,
		DRV_RES_DOWN = 3'h3,
		DRV_OD_LOW = 3'h4,
		DRV_OD_HIGH = 3'h5,
		DRV_STRONG = 3'h6,
		DRV_RES_BOTH = 3'h7
	} gpdi_drive_t;

	// Interrupt edge types
	typedef enum logic [1:0] {
		IT_NONE = 2'h0,
		IT_RISE = 2'h1,
		IT_FALL = 2'h2,
		IT_BOTH = 2'h3
	} gpdi_irq_type_t;

	// ==========================================
	// Register byte offsets (port form)
	localparam logic [7:0] OFS_OUT_VALUE = 8'h00;
	localparam logic [7:0] OFS_DRIVE0 = 8'h04;
	localparam logic [7:0] OFS_DRIVE1 = 8'h08;
	localparam logic [7:0] OFS_DRIVE2 = 8'h0C;
	localparam logic [7:0] OFS_BYPASS = 8'h10;
	localparam logic [7:0] OFS_SLEW = 8'h14;
	localparam logic [7:0] OFS_IN_DISABLE = 8'h18;
	localparam logic [7:0] OFS_PORT_CTL = 8'h1C;
	localparam logic [7:0] OFS_PIN_STATE = 8'h20;
	localparam logic [7:0] OFS_IRQ_TYPE = 8'h24;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFS_AUX_EN = 8'h2C;
	localparam logic [7:0] OFS_AUX_SEL = 8'h30;
	localparam logic [7:0] OFS_SPECIAL = 8'h34;
	// Pin form: one word per pin from this base
	localparam logic [7:0] OFS_PIN_BASE = 8'h40;

	// Pin form field positions
	localparam int PF_OUT = 0;
	localparam int PF_DRIVE_LO = 1;
	localparam int PF_DRIVE_HI = 3;
	localparam int PF_BYPASS = 4;
	localparam int PF_SLEW = 5;
	localparam int PF_IN_DIS = 6;
	localparam int PF_PIN_STATE = 7;

	// Port control fields
	localparam int PC_LVTTL = 0;
	localparam int PC_REGULATED = 1;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_IRQ_TYPE = 16'h0000;
	localparam logic [31:0] RST_AUX_SEL = 32'h00000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== test/gpdi_port_monitor.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checks for one pin port
module gpdi_port_monitor
	import gpdi_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gpdi_pkg::PINS-1:0] pinIn,
	input wire logic [gpdi_pkg::PINS-1:0] pinStrongEn,
	input wire logic [gpdi_pkg::PINS-1:0] pinResEn,
	input wire logic [gpdi_pkg::PINS-1:0] pinSlowSlew,
	input wire logic [gpdi_pkg::PINS-1:0] pinInBufEn,
	input wire logic [gpdi_pkg::PINS-1:0] pinInValue,
	input wire logic portIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_slew_strong:
		assert property ((pinSlowSlew & ~pinStrongEn) == 8'h00) else $error("Slow slew undriven");
	chk_one_driver:
		assert property ((pinStrongEn & pinResEn) == 8'h00) else $error("Two drivers on a pin");
	chk_input_gated:
		assert property ((pinInValue & ~pinInBufEn) == 8'h00)
			else $error("Input value with buffer off");
	chk_irq_hold:
		assert property (portIrq && !(s_axi_arvalid && s_axi_arready)
			&& !$past(s_axi_arvalid && s_axi_arready) |=> portIrq) else $error("Request dropped");
	chk_irq_cause:
		assert property ($rose(portIrq) |-> ($past(pinIn, 3) != $past(pinIn, 4))
			|| ($past(pinIn, 4) != $past(pinIn, 5))) else $error("Request without pin edge");
	chk_read_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("No read data");
	chk_rdata_stand:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
			else $error("Read data not held");
	chk_bresp_stand:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("Response dropped");
	chk_resp_retire:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("Response kept");
	chk_read_retire:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("Read data kept");
endmodule

bind gpdi_port gpdi_port_monitor MON (.clk, .reset_n, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .pinIn,
	.pinStrongEn, .pinResEn, .pinSlowSlew, .pinInBufEn, .pinInValue, .portIrq);

// ==== test/gpdi_pad_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Board side of the pins: weak pull per pin
module gpdi_pad_model
	import gpdi_pkg::*;
(
	input wire logic [gpdi_pkg::PINS-1:0] pinOut,
	input wire logic [gpdi_pkg::PINS-1:0] pinStrongEn,
	input wire logic [gpdi_pkg::PINS-1:0] pinResEn,
	input wire logic [gpdi_pkg::PINS-1:0] extPull,
	output logic [gpdi_pkg::PINS-1:0] padLevel
);
	// Any port driver overrides the weak board pull
	always_comb begin
		padLevel = ((pinStrongEn | pinResEn) & pinOut) | (~(pinStrongEn | pinResEn) & extPull);
	end
endmodule

// ==== test/gpio_drive_and_pin_irq_tb_top.sv ====
`timescale 1ns/1ps
module gpio_drive_and_pin_irq_tb_top;
	import gpdi_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [PINS-1:0] logicOut = 8'h04, extPull = 8'h00;
	logic [AUX_LINES-1:0] auxOutEn = 16'h0000;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic lvttlSelect, portIrq;
	logic [PINS-1:0] pinIn, pinOut, pinStrongEn, pinResEn, pinSlowSlew, pinInBufEn, pinInValue;
	int nMismatch = 0;
	int totalChecks = 0;
	// Rows: drive code, data, expected strong enable, expected resistive enable
	logic [5:0] rows [16] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h12, 6'h15, 6'h19, 6'h1E,
		6'h22, 6'h24, 6'h28, 6'h2E, 6'h32, 6'h36, 6'h39, 6'h3D};

	gpdi_port DUT (.*);
	gpdi_pad_model PAD (.pinOut, .pinStrongEn, .pinResEn, .extPull, .padLevel(pinIn));

	initial begin
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Compare and bus tasks
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		check_val({30'h0, got}, {30'h0, exp}, "response");
	endtask

	task automatic give_verdict;
		$display("Checks made %0d, mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wait_fail;
		nMismatch++;
		$display("wrong value at %0t: handshake timeout", $time);
		give_verdict();
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, done;
		@(posedge clk);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		done = 1'b0;
		for (int k = 0; k < 50 && !done; k++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid;
			if (done) check_resp(s_axi_bresp, er);
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!done) wait_fail();
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, done;
		@(posedge clk);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		done = 1'b0;
		for (int k = 0; k < 50 && !done; k++) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!done) wait_fail();
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		settle(1);
		check_val({pinStrongEn, pinResEn, pinInBufEn, 7'h00, portIrq}, 32'h0, "reset pins");
		bus_read(OFS_DRIVE0, rd, rr);
		check_val(rd, 32'h0, "reset code");
		$display("Test reset done");
		for (int i = 0; i < 16; i++) begin
			bus_write(OFS_PIN_BASE + 8'h08, {26'h0, 2'b10, rows[i][5:2]}, RESP_OKAY);
			settle(3);
			check_val({30'h0, pinStrongEn[2], pinResEn[2]}, {30'h0, rows[i][1:0]}, "enables");
			check_val({31'h0, pinSlowSlew[2]}, {31'h0, rows[i][1] & rows[i][5]}, "slew");
			check_val({31'h0, pinInBufEn[2]}, {31'h0, rows[i][5:3] != 3'h0}, "buffer");
			if (|rows[i][1:0]) check_val({31'h0, pinOut[2]}, {31'h0, rows[i][2]}, "level");
			bus_read(OFS_DRIVE1, rd, rr);
			check_val({31'h0, rd[2]}, {31'h0, rows[i][4]}, "port form bit");
		end
		$display("Test drive table done");
		bus_write(OFS_DRIVE1, 32'hFF, RESP_OKAY);
		bus_write(OFS_DRIVE2, 32'hFF, RESP_OKAY);
		bus_read(OFS_PIN_BASE + 8'h14, rd, rr);
		check_val({29'h0, rd[3:1]}, 32'h6, "pin form code");
		bus_write(OFS_PIN_BASE + 8'h08, 32'h1C, RESP_OKAY);
		settle(3);
		check_val({31'h0, pinOut[2]}, 32'h1, "bypass high");
		@(posedge clk);
		logicOut <= 8'h00;
		settle(3);
		check_val({31'h0, pinOut[2]}, 32'h0, "bypass low");
		bus_write(OFS_AUX_SEL, 32'h500, RESP_OKAY);
		bus_write(OFS_AUX_EN, 32'h04, RESP_OKAY);
		settle(3);
		check_val({31'h0, pinStrongEn[2]}, 32'h0, "aux off");
		@(posedge clk);
		auxOutEn <= 16'h0020;
		settle(3);
		check_val({31'h0, pinStrongEn[2]}, 32'h1, "aux on");
		bus_write(OFS_PORT_CTL, 32'h03, RESP_OKAY);
		bus_write(OFS_SPECIAL, 32'h04, RESP_OKAY);
		bus_write(OFS_PIN_BASE + 8'h08, 32'h0E, RESP_OKAY);
		bus_read(OFS_PIN_BASE + 8'h08, rd, rr);
		check_val({29'h0, rd[3:1]}, 32'h6, "regulated code kept");
		check_val({31'h0, lvttlSelect}, 32'h1, "threshold");
		$display("Test forms, bypass, aux done");
		bus_write(OFS_PIN_BASE + 8'h0C, 32'h02, RESP_OKAY);
		for (int t = 0; t < 4; t++) begin
			bus_write(OFS_IRQ_TYPE, {24'h0, t[1:0], 6'h00}, RESP_OKAY);
			for (int e = 0; e < 2; e++) begin
				@(posedge clk);
				extPull <= (e == 0) ? 8'h08 : 8'h00;
				settle(6);
				check_val({31'h0, portIrq}, {31'h0, t[e]}, "request");
				bus_read(OFS_IRQ_STATUS, rd, rr);
				check_val(rd, {28'h0, t[e], 3'h0}, "status");
				settle(2);
				check_val({31'h0, portIrq}, 32'h0, "request after read");
			end
		end
		$display("Test edge types done");
		@(posedge clk);
		extPull <= 8'h08;
		settle(6);
		check_val({31'h0, pinInValue[3]}, 32'h1, "input on");
		bus_write(OFS_PIN_BASE + 8'h0C, 32'h42, RESP_OKAY);
		settle(3);
		check_val({31'h0, pinInValue[3]}, 32'h0, "input disabled");
		@(posedge clk);
		s_axi_wstrb <= 4'h0;
		bus_write(OFS_SLEW, 32'hFF, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		bus_read(OFS_SLEW, rd, rr);
		check_val(rd, 32'h0, "masked write");
		bus_write(8'h3C, 32'h0, RESP_SLVERR);
		bus_write(OFS_PIN_STATE, 32'h0, RESP_SLVERR);
		bus_read(8'h3C, rd, rr);
		check_resp(rr, RESP_SLVERR);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		settle(1);
		check_val({16'h0, pinStrongEn, pinResEn}, 32'h0, "second reset");
		$display("Test refusals and reset done");
		give_verdict();
	end
endmodule
